//--- hdl/fiec_pkg.sv
// Purpose: Shared constants for the flash erase/write controller
// Assumes: Byte-wide register port, 25 MHz reference clock
// Notes:   Register offsets are byte indices on the register port
package fiec_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [3:0] FIEC_OFS_ADDR_LO  = 4'h0;
   localparam logic [3:0] FIEC_OFS_ADDR_HI  = 4'h1;
   localparam logic [3:0] FIEC_OFS_DATA_LO  = 4'h2;
   localparam logic [3:0] FIEC_OFS_DATA_HI  = 4'h3;
   localparam logic [3:0] FIEC_OFS_KEY1_LO  = 4'h4;
   localparam logic [3:0] FIEC_OFS_KEY1_HI  = 4'h5;
   localparam logic [3:0] FIEC_OFS_KEY2_LO  = 4'h6;
   localparam logic [3:0] FIEC_OFS_KEY2_HI  = 4'h7;
   localparam logic [3:0] FIEC_OFS_KEY3_LO  = 4'h8;
   localparam logic [3:0] FIEC_OFS_KEY3_HI  = 4'h9;
   localparam logic [3:0] FIEC_OFS_MAIN_CTL = 4'hA;
   localparam logic [3:0] FIEC_OFS_BUF_CLR  = 4'hB;

   // ----------------------------------------
   // Main control fields
   // ----------------------------------------
   localparam int FIEC_BIT_ENABLED  = 7;
   localparam int FIEC_MODE_MSB     = 6;
   localparam int FIEC_MODE_LSB     = 4;
   localparam int FIEC_BIT_UNLOCK   = 3;
   localparam int FIEC_BIT_INITIATE = 2;
   localparam int FIEC_BIT_BUF_CLR  = 0;

   localparam logic [2:0] FIEC_MODE_WRITE  = 3'h0;
   localparam logic [2:0] FIEC_MODE_ERASE  = 3'h1;
   localparam logic [2:0] FIEC_MODE_UNLOCK = 3'h6;

   // ----------------------------------------
   // Unlock key
   // ----------------------------------------
   localparam logic [7:0] FIEC_KEY1_LO = 8'h00;
   localparam logic [7:0] FIEC_KEY2_LO = 8'h0D;
   localparam logic [7:0] FIEC_KEY3_LO = 8'hC3;
   localparam logic [7:0] FIEC_KEY1_HI = 8'h04;
   localparam logic [7:0] FIEC_KEY2_HI = 8'h09;
   localparam logic [7:0] FIEC_KEY3_HI = 8'h40;

   // ----------------------------------------
   // Geometry, reset values, timing
   // ----------------------------------------
   localparam int         FIEC_PAGE_WORDS = 32;
   localparam logic [4:0] FIEC_PAGE_LAST  = 5'h1F;
   localparam logic [7:0] FIEC_RST_BYTE   = 8'h00;
   localparam logic [15:0] FIEC_ERASED    = 16'h0000;

   localparam int FIEC_CLK_MHZ        = 25;
   localparam int FIEC_UNLOCK_WIN_US  = 100;
   localparam int FIEC_UNLOCK_CYCLES  = FIEC_UNLOCK_WIN_US * FIEC_CLK_MHZ;
   localparam int FIEC_BUSY_CYCLES    = 4;

   typedef enum logic [1:0] {
      FIEC_IDLE,
      FIEC_ERASE,
      FIEC_WRITE,
      FIEC_DONE
   } fiec_state_t;

endpackage

//--- hdl/fiec_unlock_timer.sv
// Purpose: Unlock window timer
// Assumes: start is a one-cycle pulse
// Notes:   A restart reloads the full window
`timescale 1ns/10ps
module fiec_unlock_timer
   import fiec_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic start_i,
   output logic      running_o,
   output logic      expire_o
);

   typedef struct packed {
      logic [11:0] cnt;
      logic        run;
   } fiec_tmr_t;

   fiec_tmr_t s_q;
   fiec_tmr_t s_d;

   always_comb begin
      s_d = s_q;
      if (start_i) begin
         s_d.cnt = 12'(FIEC_UNLOCK_CYCLES - 1);
         s_d.run = 1'b1;
      end else if (s_q.run) begin
         if (s_q.cnt == 12'h000) begin
            s_d.run = 1'b0;
         end else begin
            s_d.cnt = s_q.cnt - 12'h001;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign running_o = s_q.run;
   assign expire_o  = s_q.run && !start_i && (s_q.cnt == 12'h000);

endmodule

//--- hdl/fiec_flash_array.sv
// Purpose: Behavioural flash array with per-word erase and program
// Assumes: One operation per cycle, 13-bit word address
// Notes:   Erased words read as zero; reset clears only the read data, not the words
`timescale 1ns/10ps
module fiec_flash_array
   import fiec_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        erase_i,
   input  wire logic        prog_i,
   input  wire logic [12:0] addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic [12:0] raddr_i,
   output logic      [15:0] rdata_o
);

   logic [15:0] mem_q [8192];

   always_ff @(posedge ref_clk_i) begin
      if (erase_i) begin
         mem_q[addr_i] <= FIEC_ERASED;
      end else if (prog_i) begin
         mem_q[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= mem_q[raddr_i];
      end
   end

endmodule

//--- hdl/fiec_ctrl.sv
// Purpose: In-application flash erase and write controller
// Assumes: Byte register port, read data one cycle after read strobe
// Notes:   CPU is stalled while an erase or write runs
//          Writes are ignored while a sweep runs
//          Flash read mode is not built here; its bits read as zero
//          Loaded marks survive a completed write, so a retry rewrites
//          the same page; only a buffer clear drops them
//          The unlock key is checked once, as the window closes
//
// What this block does
// - Buffer clear bit clears buffer, self-clears
// - Successful unlock sets enabled flag
// - Erase and write need enabled flag
// - Tag writes advance address, saturate 11111b
// - Erase touches only tagged addresses
// - Erased words read zero
// - Unlock trigger starts key window timer
// - Timer expiry clears unlock trigger
// - Wrong key stays disabled, right enables
// - Clearing enabled flag disables at once
// - Buffer is one 32-word page
// - Each word write below slot 31 advances buffer address
// - Mode 001 erases, 000 writes
// - Initiate bit runs operation, self-clears
// - CPU halted during erase or write
// - High byte write loads word, bumps address
// - Mode field sits in bits 6 to 4
// - Writing one to enabled flag ignored
`timescale 1ns/10ps
module fiec_ctrl
   import fiec_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic [12:0] tbl_addr_i,
   output logic      [15:0] tbl_data_o,
   output logic             cpu_stall_o,
   output logic             erase_write_enabled_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]  addr_lo;
      logic [4:0]  addr_hi;
      logic [7:0]  data_lo;
      logic [7:0]  data_hi;
      logic [7:0]  k1_lo;
      logic [7:0]  k1_hi;
      logic [7:0]  k2_lo;
      logic [7:0]  k2_hi;
      logic [7:0]  k3_lo;
      logic [7:0]  k3_hi;
      logic        enabled;
      logic [2:0]  mode;
      logic        unlock;
      logic        initiate;
      logic        buf_clr;
      logic [31:0] tag;
      logic [31:0] loaded;
      logic [4:0]  idx;
      logic [2:0]  busy;
      fiec_state_t st;
      logic [7:0]  rdata;
   } fiec_ctl_t;

   fiec_ctl_t   s_q;
   fiec_ctl_t   s_d;
   logic [15:0] wbuf_q [FIEC_PAGE_WORDS];
   logic        buf_load;
   logic [4:0]  buf_ofs;
   logic        tmr_start;
   logic        tmr_run;
   logic        tmr_expire;
   logic        key_ok;
   logic        arr_erase;
   logic        arr_prog;
   logic [12:0] arr_addr;
   logic        wr_main;
   logic [7:0]  key_seen [6];
   logic [5:0]  key_hit;
   logic [11:0] wr_sel;
   logic        op_erase;
   logic        op_write;
   logic [7:0]  main_ctl_rd;
   logic [7:0]  rd_byte;
   logic        sweep_last;
   logic [15:0] wbuf_word;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   fiec_unlock_timer u_timer (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (tmr_start),
      .running_o (tmr_run),
      .expire_o  (tmr_expire)
   );

   fiec_flash_array u_array (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .erase_i   (arr_erase),
      .prog_i    (arr_prog),
      .addr_i    (arr_addr),
      .wdata_i   (wbuf_word),
      .raddr_i   (tbl_addr_i),
      .rdata_o   (tbl_data_o)
   );

   // ----------------------------------------
   // Unlock key match
   // ----------------------------------------
   localparam logic [7:0] KEY_WANT [6] = '{FIEC_KEY1_LO, FIEC_KEY2_LO,
                                          FIEC_KEY3_LO, FIEC_KEY1_HI,
                                          FIEC_KEY2_HI, FIEC_KEY3_HI};

   assign key_seen[0] = s_q.k1_lo;
   assign key_seen[1] = s_q.k2_lo;
   assign key_seen[2] = s_q.k3_lo;
   assign key_seen[3] = s_q.k1_hi;
   assign key_seen[4] = s_q.k2_hi;
   assign key_seen[5] = s_q.k3_hi;

   // Every byte must match; a partial key never unlocks
   for (genvar k = 0; k < 6; k++) begin : g_key
      assign key_hit[k] = (key_seen[k] == KEY_WANT[k]);
   end
   assign key_ok = &key_hit;

   // ----------------------------------------
   // Register write select
   // ----------------------------------------
   // The bus is shut while a sweep runs, so nothing can move the page
   // or the buffer under an operation in progress
   for (genvar r = 0; r < 12; r++) begin : g_wsel
      assign wr_sel[r] = reg_wr_i && (reg_addr_i == 4'(r))
                      && (s_q.st == FIEC_IDLE);
   end

   assign wr_main   = wr_sel[FIEC_OFS_MAIN_CTL];
   // Trigger only counts in unlock mode and on a rising write of the bit;
   // an open window is never restarted
   assign tmr_start = wr_main && reg_wdata_i[FIEC_BIT_UNLOCK]
                   && !s_q.unlock && !tmr_run
                   && (reg_wdata_i[FIEC_MODE_MSB:FIEC_MODE_LSB]
                       == FIEC_MODE_UNLOCK);

   assign buf_load = wr_sel[FIEC_OFS_DATA_HI];
   assign buf_ofs  = s_q.addr_lo[4:0];

   // ----------------------------------------
   // Operation decode
   // ----------------------------------------
   // Anything but the two operation codes, or a locked array, is refused
   // and only drops the initiate bit
   assign op_erase = s_q.enabled && (s_q.mode == FIEC_MODE_ERASE);
   assign op_write = s_q.enabled && (s_q.mode == FIEC_MODE_WRITE);

   // ----------------------------------------
   // Page sweep
   // ----------------------------------------
   // All 32 slots are visited in order; unmarked slots are skipped, so a
   // short load leaves the rest of the page as it was
   assign sweep_last = (s_q.idx == FIEC_PAGE_LAST);
   assign wbuf_word  = wbuf_q[s_q.idx];
   assign arr_addr  = {s_q.addr_hi, s_q.addr_lo[7:5], s_q.idx};
   assign arr_erase = (s_q.st == FIEC_ERASE) && s_q.tag[s_q.idx];
   assign arr_prog  = (s_q.st == FIEC_WRITE) && s_q.loaded[s_q.idx];

   // ----------------------------------------
   // Write buffer words
   // ----------------------------------------
   // A clear wins over a load in the same cycle
   for (genvar i = 0; i < FIEC_PAGE_WORDS; i++) begin : g_wbuf
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            wbuf_q[i] <= 16'h0000;
         end else if (s_q.buf_clr) begin
            wbuf_q[i] <= 16'h0000;
         end else if (buf_load && (buf_ofs == 5'(i))) begin
            wbuf_q[i] <= {reg_wdata_i, s_q.data_lo};
         end
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rdata = reg_rd_i ? rd_byte : 8'h00;

      // Buffer clear takes one cycle; flag drops afterwards
      if (s_q.buf_clr) begin
         s_d.buf_clr = 1'b0;
         s_d.loaded  = '0;
         s_d.tag     = '0;
      end

      if (|wr_sel) begin
         unique case (reg_addr_i)
            FIEC_OFS_ADDR_LO: s_d.addr_lo = reg_wdata_i;
            FIEC_OFS_ADDR_HI: s_d.addr_hi = reg_wdata_i[4:0];
            FIEC_OFS_DATA_LO: s_d.data_lo = reg_wdata_i;
            FIEC_OFS_DATA_HI: begin
               s_d.data_hi = reg_wdata_i;
               s_d.tag[buf_ofs]    = 1'b1;
               s_d.loaded[buf_ofs] = 1'b1;
               if (buf_ofs != FIEC_PAGE_LAST) begin
                  s_d.addr_lo = s_q.addr_lo + 8'h01;
               end
            end
            FIEC_OFS_KEY1_LO: s_d.k1_lo = reg_wdata_i;
            FIEC_OFS_KEY1_HI: s_d.k1_hi = reg_wdata_i;
            FIEC_OFS_KEY2_LO: s_d.k2_lo = reg_wdata_i;
            FIEC_OFS_KEY2_HI: s_d.k2_hi = reg_wdata_i;
            FIEC_OFS_KEY3_LO: s_d.k3_lo = reg_wdata_i;
            FIEC_OFS_KEY3_HI: s_d.k3_hi = reg_wdata_i;
            FIEC_OFS_MAIN_CTL: begin
               s_d.mode = reg_wdata_i[FIEC_MODE_MSB:FIEC_MODE_LSB];
               if (!reg_wdata_i[FIEC_BIT_ENABLED]) begin
                  s_d.enabled = 1'b0;
               end
               if (tmr_start) begin
                  s_d.unlock = 1'b1;
               end
               if (reg_wdata_i[FIEC_BIT_INITIATE]) begin
                  s_d.initiate = 1'b1;
               end
            end
            FIEC_OFS_BUF_CLR: begin
               if (reg_wdata_i[FIEC_BIT_BUF_CLR]) begin
                  s_d.buf_clr = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // Key is checked as the window closes; this follows the register
      // write so that the hardware set wins over a software clear
      if (tmr_expire) begin
         s_d.unlock = 1'b0;
         if (key_ok && s_q.mode == FIEC_MODE_UNLOCK) begin
            s_d.enabled = 1'b1;
         end
      end

      unique case (s_q.st)
         FIEC_IDLE: begin
            if (s_q.initiate) begin
               s_d.idx = 5'h00;
               if (op_erase) begin
                  s_d.st = FIEC_ERASE;
               end else if (op_write) begin
                  s_d.st = FIEC_WRITE;
               end else begin
                  s_d.initiate = 1'b0;
               end
            end
         end
         FIEC_ERASE, FIEC_WRITE: begin
            if (sweep_last) begin
               s_d.st   = FIEC_DONE;
               s_d.busy = 3'(FIEC_BUSY_CYCLES - 1);
            end else begin
               s_d.idx = s_q.idx + 5'h01;
            end
         end
         FIEC_DONE: begin
            if (s_q.busy == 3'h0) begin
               s_d.st       = FIEC_IDLE;
               s_d.initiate = 1'b0;
               s_d.tag      = '0;
            end else begin
               s_d.busy = s_q.busy - 3'h1;
            end
         end
      endcase
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   // Read-mode bits are not built and read back as zero
   assign main_ctl_rd = {s_q.enabled, s_q.mode, s_q.unlock, s_q.initiate,
                         2'h0};

   always_comb begin
      rd_byte = 8'h00;
      unique case (reg_addr_i)
         FIEC_OFS_ADDR_LO:  rd_byte = s_q.addr_lo;
         FIEC_OFS_ADDR_HI:  rd_byte = {3'h0, s_q.addr_hi};
         FIEC_OFS_DATA_LO:  rd_byte = s_q.data_lo;
         FIEC_OFS_DATA_HI:  rd_byte = s_q.data_hi;
         FIEC_OFS_KEY1_LO:  rd_byte = s_q.k1_lo;
         FIEC_OFS_KEY1_HI:  rd_byte = s_q.k1_hi;
         FIEC_OFS_KEY2_LO:  rd_byte = s_q.k2_lo;
         FIEC_OFS_KEY2_HI:  rd_byte = s_q.k2_hi;
         FIEC_OFS_KEY3_LO:  rd_byte = s_q.k3_lo;
         FIEC_OFS_KEY3_HI:  rd_byte = s_q.k3_hi;
         FIEC_OFS_MAIN_CTL: rd_byte = main_ctl_rd;
         FIEC_OFS_BUF_CLR:  rd_byte = {7'h00, s_q.buf_clr};
         default:           rd_byte = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q    <= '0;
         s_q.st <= FIEC_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o           = s_q.rdata;
   assign cpu_stall_o           = (s_q.st != FIEC_IDLE);
   assign erase_write_enabled_o = s_q.enabled;

endmodule

//--- dv/fiec_flash_model.sv
// Purpose: Shadow of the flash array contents the bench expects
// Assumes: Bench calls it for every erase or program it commands
// Notes:   Words never written read back unknown
`timescale 1ns/10ps
module fiec_flash_model
   import fiec_pkg::*;
   ;
   logic [15:0] mem [logic [12:0]];

   function automatic void program_word(input logic [12:0] a,
                                        input logic [15:0] d);
      mem[a] = d;
   endfunction

   // Only tagged words are cleared; neighbours keep their data
   function automatic void erase_word(input logic [12:0] a);
      mem[a] = FIEC_ERASED;
   endfunction

   function automatic logic [15:0] peek(input logic [12:0] a);
      return mem.exists(a) ? mem[a] : 16'hXXXX;
   endfunction
endmodule

//--- dv/fiec_ctrl_props.sv
// Purpose: Port assertions for the flash erase/write controller
// Assumes: One clock, asynchronous active-high reset
// Notes:   Busy time is the page sweep plus the done delay
`timescale 1ns/10ps
module fiec_ctrl_props
   import fiec_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        sys_rst_i,
   input wire logic [3:0]  reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic [12:0] tbl_addr_i,
   input wire logic [15:0] tbl_data_o,
   input wire logic        cpu_stall_o,
   input wire logic        erase_write_enabled_o
);
   localparam logic [7:0] STALL_LEN = 8'(FIEC_PAGE_WORDS + FIEC_BUSY_CYCLES);
   logic [7:0] stall_cnt_q;
   logic       ctl_wr;

   // Writes during a stall are dropped, so they are not a cause
   assign ctl_wr = reg_wr_i && reg_addr_i == FIEC_OFS_MAIN_CTL && !cpu_stall_o;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stall_cnt_q <= 8'h00;
      end else begin
         stall_cnt_q <= cpu_stall_o ? stall_cnt_q + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   AST_EN_NO_SW_SET: assert property (ctl_wr && reg_wdata_i[7] &&
      !erase_write_enabled_o |=> !erase_write_enabled_o)
      else $error("enabled flag set by a register write");
   AST_EN_SW_CLR: assert property (ctl_wr && !reg_wdata_i[7]
      |=> !erase_write_enabled_o)
      else $error("enabled flag not cleared by software");
   AST_GO_STALLS: assert property (ctl_wr && reg_wdata_i[2] &&
      reg_wdata_i[7] && !reg_wdata_i[3] && reg_wdata_i[6:5] == 2'b00 &&
      erase_write_enabled_o |=> ##1 cpu_stall_o)
      else $error("initiate did not stall the CPU");
   AST_RSV_IDLE: assert property (ctl_wr && reg_wdata_i[2] &&
      reg_wdata_i[6:5] != 2'b00 |=> !cpu_stall_o [*2])
      else $error("reserved mode started an operation");
   AST_STALL_NEEDS_EN: assert property ($rose(cpu_stall_o)
      |-> $past(erase_write_enabled_o))
      else $error("operation started while disabled");
   AST_STALL_LEN: assert property ($fell(cpu_stall_o)
      |-> stall_cnt_q == STALL_LEN)
      else $error("busy time differs from sweep plus done delay");
   AST_STALL_FREEZE: assert property (cpu_stall_o && $past(cpu_stall_o)
      |-> $stable(erase_write_enabled_o))
      else $error("enabled flag moved during a stall");
   AST_BUFCLR_DONE: assert property (reg_rd_i &&
      reg_addr_i == FIEC_OFS_BUF_CLR && !$past(reg_wr_i) &&
      !$past(reg_wr_i, 2) |=> reg_rdata_o == 8'h00)
      else $error("buffer clear bit did not return to zero");

   cover property ($rose(erase_write_enabled_o));
   cover property ($fell(cpu_stall_o));
   cover property (ctl_wr && reg_wdata_i[2] && !erase_write_enabled_o);
endmodule

//--- dv/tb.sv
// Purpose: Self-checking bench for the flash erase/write controller
// Assumes: Read data one cycle after the read strobe
// Notes:   Unlock window runs at full length, about 2500 cycles
`timescale 1ns/10ps
module tb
   import fiec_pkg::*;
   ;
   logic        ref_clk_i   = 1'b0;
   logic        sys_rst_i   = 1'b1;
   logic [3:0]  reg_addr_i  = 4'h0;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_wr_i    = 1'b0;
   logic        reg_rd_i    = 1'b0;
   logic [12:0] tbl_addr_i  = 13'h0000;
   logic [7:0]  reg_rdata_o;
   logic [15:0] tbl_data_o;
   logic        cpu_stall_o;
   logic        erase_write_enabled_o;
   int          mismatches = 0;
   int          samples_checked = 0;
   logic [7:0]  rv;
   logic [15:0] tv;

   always #20 ref_clk_i = ~ref_clk_i;

   fiec_ctrl dut (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .tbl_addr_i(tbl_addr_i), .tbl_data_o(tbl_data_o),
      .cpu_stall_o(cpu_stall_o),
      .erase_write_enabled_o(erase_write_enabled_o));
   fiec_flash_model flash_mdl ();

   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [15:0] ex,
                      input logic [15:0] got);
      samples_checked++;
      if (got !== ex) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 rv = reg_rdata_o;
   endtask
   task automatic cmpf(input logic [12:0] a);
      @(posedge ref_clk_i);
      tbl_addr_i <= a;
      @(posedge ref_clk_i);
      #1 tv = tbl_data_o;
      chk("flash word", flash_mdl.peek(a), tv);
   endtask
   task automatic setad(input logic [7:0] hi, input logic [7:0] lo);
      wr(FIEC_OFS_ADDR_LO, lo);
      wr(FIEC_OFS_ADDR_HI, hi);
   endtask
   task automatic ld(input logic [15:0] w);
      wr(FIEC_OFS_DATA_LO, w[7:0]);
      wr(FIEC_OFS_DATA_HI, w[15:8]);
   endtask
   task automatic run(input logic [7:0] cmd, input logic busy);
      int n = 0;
      wr(FIEC_OFS_MAIN_CTL, cmd);
      // The sweep starts one cycle after the initiate bit is stored
      @(posedge ref_clk_i);
      #1 chk("stall", 16'(busy), 16'(cpu_stall_o));
      while (cpu_stall_o === 1'b1 && n < 100) begin
         @(posedge ref_clk_i);
         #1 n++;
      end
      chk("stall end", 16'h0000, 16'(cpu_stall_o));
      rd(FIEC_OFS_MAIN_CTL);
      chk("initiate", 16'h0000, 16'(rv[FIEC_BIT_INITIATE]));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      for (int a = 0; a < 16; a++) begin
         rd(4'(a));
         chk("reset value", 16'h0000, 16'(rv));
      end
      $display("Test reset done");
   endtask
   task automatic unlock(input logic [7:0] last, input logic en);
      logic [7:0] key [6];
      int         n = 0;
      key = '{FIEC_KEY1_LO, FIEC_KEY1_HI, FIEC_KEY2_LO, FIEC_KEY2_HI,
              FIEC_KEY3_LO, last};
      wr(FIEC_OFS_MAIN_CTL, 8'h68);
      rd(FIEC_OFS_MAIN_CTL);
      chk("trigger", 16'h0001, 16'(rv[FIEC_BIT_UNLOCK]));
      chk("mode", 16'(FIEC_MODE_UNLOCK), 16'(rv[6:4]));
      for (int i = 0; i < 6; i++) begin
         wr(FIEC_OFS_KEY1_LO + 4'(i), key[i]);
      end
      do begin
         rd(FIEC_OFS_MAIN_CTL);
         n++;
      end while (rv[FIEC_BIT_UNLOCK] === 1'b1 && n < FIEC_UNLOCK_CYCLES);
      chk("window", 16'h0001, 16'(n > FIEC_UNLOCK_CYCLES / 2 - 20 &&
          n < FIEC_UNLOCK_CYCLES / 2 + 5));
      chk("enabled", 16'(en), 16'(erase_write_enabled_o));
      $display("Test unlock done");
   endtask
   task automatic t_write;
      setad(8'h01, 8'h1E);
      ld(16'h1234);
      ld(16'hBEEF);
      ld(16'hC0DE);
      rd(FIEC_OFS_ADDR_LO);
      chk("buffer address", 16'h001F, 16'(rv));
      flash_mdl.program_word(13'h011E, 16'h1234);
      flash_mdl.program_word(13'h011F, 16'hC0DE);
      run(8'h84, 1'b1);
      run(8'hA4, 1'b0);
      cmpf(13'h011E);
      cmpf(13'h011F);
      $display("Test write done");
   endtask
   task automatic t_erase;
      setad(8'h01, 8'h1F);
      wr(FIEC_OFS_DATA_HI, 8'h00);
      wr(FIEC_OFS_DATA_HI, 8'h00);
      rd(FIEC_OFS_ADDR_LO);
      chk("tag address", 16'h001F, 16'(rv));
      flash_mdl.erase_word(13'h011F);
      run(8'h94, 1'b1);
      cmpf(13'h011F);
      cmpf(13'h011E);
      $display("Test erase done");
   endtask
   task automatic t_clear;
      setad(8'h01, 8'h1E);
      ld(16'h5A5A);
      wr(FIEC_OFS_BUF_CLR, 8'h01);
      rd(FIEC_OFS_BUF_CLR);
      chk("clear bit", 16'h0000, 16'(rv));
      run(8'h84, 1'b1);
      cmpf(13'h011E);
      $display("Test clear done");
   endtask
   task automatic t_disable;
      wr(FIEC_OFS_MAIN_CTL, 8'h00);
      #1 chk("disabled", 16'h0000, 16'(erase_write_enabled_o));
      run(8'h84, 1'b0);
      chk("still off", 16'h0000, 16'(erase_write_enabled_o));
      $display("Test disable done");
   endtask

   task automatic print_verdict;
      $display("Checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      t_reset;
      t_disable;
      unlock(FIEC_KEY3_HI ^ 8'h01, 1'b0);
      unlock(FIEC_KEY3_HI, 1'b1);
      t_write;
      t_erase;
      t_clear;
      t_disable;
      print_verdict;
   end

   // A hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge ref_clk_i);
      mismatches++;
      print_verdict;
   end
endmodule

bind fiec_ctrl fiec_ctrl_props props (
   .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .tbl_addr_i(tbl_addr_i), .tbl_data_o(tbl_data_o),
   .cpu_stall_o(cpu_stall_o),
   .erase_write_enabled_o(erase_write_enabled_o));
